// [rtl/sqh_pkg.sv]
// Purpose: shared constants for the sequencer and hour-adjust block
// Assumes: 32-bit AHB-Lite register bus, 25 MHz clock
// Notes: byte offsets of the register map and field positions live here
package sqh_pkg;

    localparam int CLK_HZ = 25000000;
    localparam int TICK_PERIOD_S = 1;
    localparam int SEC_CYCLES_DEF = CLK_HZ * TICK_PERIOD_S;
    localparam int SEC_PER_MIN = 60;
    localparam int SEC_PER_HOUR = 3600;
    localparam int NOUT = 7;
    localparam int HOURS_PER_DAY = 24;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_HOUR = 8'h08;
    localparam logic [7:0] OFF_DELAY1 = 8'h10;
    localparam logic [7:0] OFF_DELAY7 = 8'h28;

    localparam int CTRL_TCNT_LSB = 0;
    localparam int CTRL_UNIT_LSB = 4;
    localparam int CTRL_STOP_LSB = 8;
    localparam int ST_TOUT_LSB = 0;
    localparam int ST_SOUT_LSB = 8;
    localparam int ST_TSTATE_LSB = 16;
    localparam int ST_SDIR_LSB = 18;
    localparam int ST_HOUR_LSB = 24;

    localparam logic [2:0] TCNT_RST = 3'h7;
    localparam logic [2:0] STOP_RST = 3'h7;
    localparam logic [2:0] STOP_MIN = 3'h1;
    localparam logic [4:0] HOUR_RST = 5'h00;
    localparam logic [4:0] HOUR_MAX = 5'h17;

    typedef enum logic [1:0] {
        SQH_UNIT_SEC,
        SQH_UNIT_MIN,
        SQH_UNIT_HOUR,
        SQH_UNIT_RSVD
    } sqh_unit_t;

    // thermometer mask: lowest n of the seven sequenced outputs
    function automatic logic [6:0] sqh_tmask(input logic [2:0] n);
        logic [6:0] m;
        m = 7'h00;
        for (int i = 0; i < NOUT; i++) begin
            if (i < int'(n)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

endpackage

// [rtl/sqh_step_seq.sv]
// Purpose: step sequencer, one output per trigger edge, then unwinds
// Assumes: trigger and clear come from logic on the same clock
// Notes: the top of the run is clamped so outputs 0 and 1 always exist
`timescale 1ns/1ps
module sqh_step_seq
    import sqh_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic trigger_in,
    input wire logic clear_in,
    input wire logic [2:0] top_sel,
    output logic [7:0] step_out,
    output logic going_down
);

    logic trig_d_r;
    logic [2:0] level_r;
    logic down_r;
    logic [2:0] top;
    logic step;

    // run always reaches output 1 at least; selection is a length
    assign top = (top_sel < STOP_MIN) ? STOP_MIN : top_sel;
    assign step = trigger_in && !trig_d_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= trigger_in;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level_r <= 3'h0;
            down_r <= 1'b0;
        end else if (clear_in) begin
            level_r <= 3'h0;
            down_r <= 1'b0;
        end else if (step) begin
            if (!down_r) begin
                if (level_r >= top) begin
                    // shrunk selection while up: start unwinding
                    level_r <= level_r - 3'h1;
                    down_r <= 1'b1;
                end else begin
                    level_r <= level_r + 3'h1;
                    down_r <= (level_r + 3'h1) == top;
                end
            end else begin
                level_r <= level_r - 3'h1;
                down_r <= (level_r != 3'h1);
            end
        end
    end

    assign step_out = {sqh_tmask(level_r), 1'b1};
    assign going_down = down_r;

endmodule

// [rtl/sqh_top.sv]
// Purpose: timed sequencer, step sequencer and hour adjust with AHB-Lite
// Assumes: control inputs come from logic on the same clock
// Notes: reads take one wait state so read data comes from a flop
`timescale 1ns/1ps
module sqh_top
    import sqh_pkg::*;
#(
    parameter int SEC_CYCLES = SEC_CYCLES_DEF
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic trigger_in,
    input wire logic timed_clear,
    input wire logic step_trigger,
    input wire logic step_clear,
    input wire logic hour_up,
    input wire logic hour_down,
    output logic [7:0] timed_sequencer,
    output logic [7:0] step_sequencer,
    output logic [4:0] hour_value
);

    typedef enum logic [1:0] {
        SQH_T_IDLE,
        SQH_T_RUN,
        SQH_T_DONE
    } sqh_tstate_t;

    // bus state
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic rd_pend_r;
    logic [7:0] rd_addr_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic accept;

    // configuration
    logic [2:0] tcnt_r;
    sqh_unit_t unit_r;
    logic [2:0] stop_r;
    logic [15:0] delay_r [NOUT];

    // timed sequencer
    sqh_tstate_t tstate_r;
    logic [24:0] presc_r;
    logic [11:0] usec_r;
    logic [15:0] elapsed_r;
    logic [6:0] tout_r;
    logic sec_tick;
    logic unit_tick;
    logic [11:0] unit_len;
    logic [6:0] tout_nxt;
    logic [6:0] tenable;

    // step sequencer and hour
    logic [7:0] step_nxt;
    logic step_down;
    logic [7:0] step_r;
    logic step_down_r;
    logic hup_d_r;
    logic hdn_d_r;
    logic [4:0] hour_r;
    logic hour_inc;
    logic hour_dec;
    logic hour_wr;

    assign accept = hsel && hready && htrans[1];
    assign hour_wr = wr_pend_r && (wr_addr_r == OFF_HOUR);

    function automatic logic is_delay(input logic [7:0] a);
        return (a >= OFF_DELAY1) && (a <= OFF_DELAY7) && (a[1:0] == 2'h0);
    endfunction

    function automatic int delay_idx(input logic [7:0] a);
        return int'((a - OFF_DELAY1) >> 2);
    endfunction

    // address phase capture; reads get one wait state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rd_pend_r <= 1'b0;
            rd_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= accept && hwrite;
            rd_pend_r <= accept && !hwrite;
            if (accept) begin
                wr_addr_r <= haddr[7:0];
                rd_addr_r <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hreadyout_r <= 1'b1;
            hrdata_r <= 32'h0000_0000;
        end else begin
            if (accept && !hwrite) begin
                hreadyout_r <= 1'b0;
            end else begin
                hreadyout_r <= 1'b1;
            end
            if (rd_pend_r) begin
                hrdata_r <= 32'h0000_0000;
                if (rd_addr_r == OFF_CTRL) begin
                    hrdata_r[CTRL_TCNT_LSB +: 3] <= tcnt_r;
                    hrdata_r[CTRL_UNIT_LSB +: 2] <= unit_r;
                    hrdata_r[CTRL_STOP_LSB +: 3] <= stop_r;
                end else if (rd_addr_r == OFF_STATUS) begin
                    hrdata_r[ST_TOUT_LSB +: 8] <= {tout_r, 1'b1};
                    hrdata_r[ST_SOUT_LSB +: 8] <= step_r;
                    hrdata_r[ST_TSTATE_LSB +: 2] <= tstate_r;
                    hrdata_r[ST_SDIR_LSB] <= step_down_r;
                    hrdata_r[ST_HOUR_LSB +: 5] <= hour_r;
                end else if (rd_addr_r == OFF_HOUR) begin
                    hrdata_r[4:0] <= hour_r;
                end else if (is_delay(rd_addr_r)) begin
                    hrdata_r[15:0] <= delay_r[delay_idx(rd_addr_r)];
                end
            end
        end
    end

    // configuration writes, data phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tcnt_r <= TCNT_RST;
            unit_r <= SQH_UNIT_SEC;
            stop_r <= STOP_RST;
            for (int i = 0; i < NOUT; i++) begin
                delay_r[i] <= 16'(i + 1);
            end
        end else if (wr_pend_r) begin
            if (wr_addr_r == OFF_CTRL) begin
                tcnt_r <= hwdata[CTRL_TCNT_LSB +: 3];
                unit_r <= sqh_unit_t'(hwdata[CTRL_UNIT_LSB +: 2]);
                stop_r <= hwdata[CTRL_STOP_LSB +: 3];
            end else if (is_delay(wr_addr_r)) begin
                delay_r[delay_idx(wr_addr_r)] <= hwdata[15:0];
            end
        end
    end

    // time base for the timed sequencer
    always_comb begin
        case (unit_r)
            SQH_UNIT_MIN: unit_len = 12'(SEC_PER_MIN);
            SQH_UNIT_HOUR: unit_len = 12'(SEC_PER_HOUR);
            default: unit_len = 12'h001;
        endcase
    end

    assign sec_tick = (presc_r == 25'(SEC_CYCLES - 1));
    assign unit_tick = sec_tick && (usec_r >= unit_len - 12'h001);
    assign tenable = sqh_tmask(tcnt_r);

    // output k needs its delay passed and output k-1 on or turning on in the same cycle
    always_comb begin
        tout_nxt = tout_r;
        for (int k = 0; k < NOUT; k++) begin
            if (tenable[k] && (elapsed_r >= delay_r[k]) &&
                ((k == 0) || tout_nxt[(k == 0) ? 0 : k - 1])) begin
                tout_nxt[k] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tstate_r <= SQH_T_IDLE;
            presc_r <= 25'h0;
            usec_r <= 12'h000;
            elapsed_r <= 16'h0000;
            tout_r <= 7'h00;
        end else if (timed_clear) begin
            tstate_r <= SQH_T_IDLE;
            presc_r <= 25'h0;
            usec_r <= 12'h000;
            elapsed_r <= 16'h0000;
            tout_r <= 7'h00;
        end else begin
            case (tstate_r)
                SQH_T_IDLE: begin
                    if (trigger_in) begin
                        tstate_r <= SQH_T_RUN;
                    end
                end
                SQH_T_RUN: begin
                    tout_r <= tout_nxt;
                    if (tout_nxt == tenable) begin
                        // all enabled outputs up: freeze until clear
                        tstate_r <= SQH_T_DONE;
                    end
                    if (sec_tick) begin
                        presc_r <= 25'h0;
                        usec_r <= unit_tick ? 12'h000 : usec_r + 12'h001;
                    end else begin
                        presc_r <= presc_r + 25'h1;
                    end
                    if (unit_tick && (elapsed_r != 16'hFFFF)) begin
                        elapsed_r <= elapsed_r + 16'h0001;
                    end
                end
                SQH_T_DONE: begin
                    tstate_r <= SQH_T_DONE;
                end
                default: tstate_r <= SQH_T_IDLE;
            endcase
        end
    end

    sqh_step_seq u_step (
        .clk(clk),
        .resetn(resetn),
        .trigger_in(step_trigger),
        .clear_in(step_clear),
        .top_sel(stop_r),
        .step_out(step_nxt),
        .going_down(step_down)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            step_r <= 8'h01;
            step_down_r <= 1'b0;
        end else begin
            step_r <= step_nxt;
            step_down_r <= step_down;
        end
    end

    // hour adjust; both edges together cancel out
    assign hour_inc = hour_up && !hup_d_r;
    assign hour_dec = hour_down && !hdn_d_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hup_d_r <= 1'b0;
            hdn_d_r <= 1'b0;
            hour_r <= HOUR_RST;
        end else begin
            hup_d_r <= hour_up;
            hdn_d_r <= hour_down;
            if (hour_wr) begin
                hour_r <= (hwdata[4:0] > HOUR_MAX) ? HOUR_MAX : hwdata[4:0];
            end else if (hour_inc && !hour_dec) begin
                hour_r <= (hour_r >= HOUR_MAX) ? 5'h00 : hour_r + 5'h01;
            end else if (hour_dec && !hour_inc) begin
                hour_r <= (hour_r == 5'h00) ? HOUR_MAX : hour_r - 5'h01;
            end
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;
    assign timed_sequencer = {tout_r, 1'b1};
    assign step_sequencer = step_r;
    assign hour_value = hour_r;

endmodule

// [verification/sqh_ctl_model.sv]
// Purpose: stands in for the function blocks feeding the controls
// Assumes: requests come from the bench on the same clock
// Notes: registered so each control is a whole-cycle level
`timescale 1ns/1ps
module sqh_ctl_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] req,
    output logic [5:0] ctl
);
    // low in reset so release shows no false edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl <= 6'h00;
        end else begin
            ctl <= req;
        end
    end
endmodule

// [verification/sqh_top_checker.sv]
// Purpose: port checker for the sequencer and hour-adjust block
// Assumes: bound to sqh_top, one clock domain
// Notes: hour checks skip the cycle after a bus select
`timescale 1ns/1ps
module sqh_top_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic step_trigger,
    input wire logic step_clear,
    input wire logic timed_clear,
    input wire logic hour_up,
    input wire logic hour_down,
    input wire logic [7:0] timed_sequencer,
    input wire logic [7:0] step_sequencer,
    input wire logic [4:0] hour_value
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_timed_zero_on: assert property (timed_sequencer[0])
        else $error("timed output 0 low");
    a_timed_run_order: assert property (
        ((timed_sequencer[7:1] + 7'h01) & timed_sequencer[7:1]) == 7'h00)
        else $error("timed outputs not a run from 1");
    a_timed_keep_on: assert property (!timed_clear |=>
        (~timed_sequencer[7:1] & $past(timed_sequencer[7:1])) == 7'h00)
        else $error("timed output fell without clear");
    a_timed_clear_drop: assert property (
        timed_clear |=> timed_sequencer == 8'h01)
        else $error("timed clear left outputs on");
    a_step_zero_on: assert property (step_sequencer[0])
        else $error("step output 0 low");
    a_step_one_bit: assert property (
        !$past(step_clear) && !$past(step_clear, 2) |->
        $onehot0(step_sequencer ^ $past(step_sequencer)))
        else $error("step moved more than one output");
    a_step_edge_only: assert property (
        step_sequencer != $past(step_sequencer) && !$past(step_clear)
        && !$past(step_clear, 2) |->
        $past(step_trigger, 2) && !$past(step_trigger, 3))
        else $error("step without a trigger edge");
    a_step_clear_wins: assert property (
        step_clear |-> ##2 step_sequencer == 8'h01)
        else $error("step clear did not win");
    a_hour_up_one: assert property (
        $rose(hour_up) && !hour_down && !$past(hsel) |=>
        hour_value == (($past(hour_value) == 5'h17) ? 5'h00 :
        $past(hour_value) + 5'h01))
        else $error("hour up wrong");
    a_hour_down_one: assert property (
        $rose(hour_down) && !hour_up && !$past(hsel) |=>
        hour_value == (($past(hour_value) == 5'h00) ? 5'h17 :
        $past(hour_value) - 5'h01))
        else $error("hour down wrong");
endmodule

bind sqh_top sqh_top_checker i_sqh_top_checker (.clk, .resetn, .hsel,
    .step_trigger, .step_clear, .timed_clear, .hour_up, .hour_down,
    .timed_sequencer, .step_sequencer, .hour_value);

// [verification/tb.sv]
// Purpose: directed bench for the sequencer and hour-adjust block
// Assumes: one second shortened to 4 clocks
// Notes: controls pass through the partner, one cycle late
`timescale 1ns/1ps
module tb
    import sqh_pkg::*;
;
    localparam int SC = 4;
    logic clk, hready, hreadyout, hresp;
    logic resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000;
    logic [31:0] hrdata, rd;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [5:0] req = 6'h00, ctl;
    logic [7:0] ts, ss;
    logic [4:0] hv;
    int bad_count = 0, tests_run = 0, lvl = 0, top = 0;
    logic up = 1'b1;
    int ucyc[3] = '{SC, SC * SEC_PER_MIN, SC * SEC_PER_HOUR};
    logic [2:0] tops[3] = '{3'h7, 3'h2, 3'h0};

    assign hready = hreadyout;
    sqh_top #(.SEC_CYCLES(SC)) i_sqh_top (.clk, .resetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
        .hresp, .trigger_in(ctl[0]), .timed_clear(ctl[1]),
        .step_trigger(ctl[2]), .step_clear(ctl[3]), .hour_up(ctl[4]),
        .hour_down(ctl[5]), .timed_sequencer(ts), .step_sequencer(ss),
        .hour_value(hv));
    sqh_ctl_model i_sqh_ctl_model (.clk, .resetn, .req, .ctl);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic summarize();
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // sample mid-cycle: the value the next rising edge will see
    task automatic phase();
        int n;
        logic r;
        n = 0;
        do begin
            @(negedge clk);
            r = hreadyout;
            rd = hrdata;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 50);
        if (r !== 1'b1) begin
            bad_count++;
            summarize();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h000000, a};
        phase();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        phase();
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(nm, e, rd);
    endtask

    task automatic pulse(input int b, input int w);
        req[b] <= 1'b1;
        repeat (w) @(posedge clk);
        req[b] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic wts(input logic [7:0] e, input int lim);
        int n;
        n = 0;
        while (ts !== e && n < lim) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        chk("timed", 32'(e), 32'(ts));
        if (ts !== e) begin
            summarize();
        end
    endtask

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk("timed rst", 32'h00000001, 32'(ts));
        chk("step rst", 32'h00000001, 32'(ss));
        chk("hour rst", 32'h00000000, 32'(hv));
        rdchk("ctrl", OFF_CTRL, 32'h00000707);
        rdchk("delay7", OFF_DELAY7, 32'h00000007);
        bus(1'b1, 8'h0C, 32'hFFFFFFFF);
        rdchk("unmapped", 8'h0C, 32'h00000000);
        pulse(0, 1);
        for (int k = 1; k <= 7; k++) begin
            wts(8'((9'h002 << k) - 9'h001), 3 * SC);
        end
        pulse(0, 1);
        repeat (40) @(posedge clk);
        chk("timed done", 32'h000000FF, 32'(ts));
        rdchk("status", OFF_STATUS, 32'h000201FF);
        chk("hresp", 32'h00000000, 32'(hresp));
        pulse(1, 1);
        chk("timed clr", 32'h00000001, 32'(ts));
        repeat (40) @(posedge clk);
        chk("timed idle", 32'h00000001, 32'(ts));
        req <= 6'h03;
        @(posedge clk);
        req <= 6'h00;
        repeat (40) @(posedge clk);
        chk("timed clr win", 32'h00000001, 32'(ts));
        foreach (ucyc[u]) begin
            bus(1'b1, OFF_CTRL, 32'h00000701 | (32'(u) << 4));
            pulse(1, 1);
            pulse(0, 1);
            if (u > 0) begin
                repeat (ucyc[u] - 12) @(posedge clk);
                chk("unit early", 32'h00000001, 32'(ts));
            end
            wts(8'h03, 24);
        end
        foreach (tops[i]) begin
            bus(1'b1, OFF_CTRL, 32'h00000007 | (32'(tops[i]) << 8));
            top = (tops[i] < 3'h2) ? 1 : int'(tops[i]);
            for (int p = 0; p < 2 * top; p++) begin
                pulse(2, 1);
                lvl = up ? lvl + 1 : lvl - 1;
                up = (lvl == top) ? 1'b0 : ((lvl == 0) ? 1'b1 : up);
                chk("step", 32'((9'h002 << lvl) - 9'h001), 32'(ss));
            end
        end
        bus(1'b1, OFF_CTRL, 32'h00000707);
        pulse(2, 1);
        pulse(2, 1);
        chk("step mid", 32'h00000007, 32'(ss));
        req <= 6'h0C;
        @(posedge clk);
        req <= 6'h00;
        repeat (4) @(posedge clk);
        chk("step clr", 32'h00000001, 32'(ss));
        pulse(2, 6);
        chk("step hold", 32'h00000003, 32'(ss));
        pulse(5, 1);
        chk("hour dn", 32'h00000017, 32'(hv));
        pulse(4, 6);
        chk("hour up", 32'h00000000, 32'(hv));
        pulse(4, 1);
        chk("hour up", 32'h00000001, 32'(hv));
        bus(1'b1, OFF_HOUR, 32'h0000001F);
        rdchk("hour clamp", OFF_HOUR, 32'h00000017);
        pulse(4, 1);
        chk("hour wrap", 32'h00000000, 32'(hv));
        summarize();
    end
endmodule
